// file: verilog/pbm_pkg.sv
// ----------------------------------------------------------------------
// Shared constants for the basic mode control and status registers
// ----------------------------------------------------------------------
package pbm_pkg;

  // Register indices on the management bus
  localparam logic [4:0]  REG_CTRL_IDX   = 5'h00;
  localparam logic [4:0]  REG_STAT_IDX   = 5'h01;

  // Control word field positions
  localparam int          CTRL_RST_BIT   = 15;
  localparam int          CTRL_LOOP_BIT  = 14;
  localparam int          CTRL_SPEED_BIT = 13;
  localparam int          CTRL_ANEN_BIT  = 12;
  localparam int          CTRL_PD_BIT    = 11;
  localparam int          CTRL_ISO_BIT   = 10;
  localparam logic [9:0]  CTRL_RSVD_VAL  = 10'h100;
  localparam logic [15:0] CTRL_FIXED     = 16'h2100;  // Speed bit and reserved pattern

  // Status word field positions and fixed pattern
  localparam int          STAT_RFAULT_BIT = 4;
  localparam int          STAT_LINK_BIT   = 2;
  localparam int          STAT_JAB_BIT    = 1;
  localparam logic [15:0] STAT_FIXED      = 16'h0061;  // Preamble supp, AN complete, ext cap

  // Timing
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          SRST_TIME_NS   = 1000;
  localparam int          SRST_CYCLES    = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  SRST_CNT_LOAD  = 6'(SRST_CYCLES);

  // Management frame fields
  localparam logic [5:0]  PREAMBLE_LAST  = 6'h1F;  // 32 ones
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  TA_WRITE       = 2'h2;
  localparam logic [5:0]  ADDR_LAST      = 6'h09;  // 10 address bits
  localparam logic [5:0]  DATA_LAST      = 6'h0F;  // 16 data bits
  localparam logic [4:0]  PHY_ADDR_DFLT  = 5'h00;

  typedef enum logic [2:0] {
    ST_PRE, ST_IDLE, ST_START, ST_OP, ST_ADDR, ST_TA, ST_DATA
  } pbm_mdio_state_type;

endpackage

// file: verilog/pbm_mgmt_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Register access carrier between frame engine and register bank
// ----------------------------------------------------------------------
interface pbm_mgmt_if;
  logic        rd_stb;
  logic        wr_stb;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport engine (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
  modport regs   (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface

// file: verilog/pbm_mdio_slave.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Serial management frame engine
// ----------------------------------------------------------------------
module pbm_mdio_slave #(
  parameter logic [4:0] PHY_ADDR = pbm_pkg::PHY_ADDR_DFLT
) (
  input  wire logic        clk,      // System clock
  input  wire logic        sys_rst,  // Async reset
  input  wire logic        mdc,      // Management clock pin
  input  wire logic        mdio_i,   // Management data in
  output logic             mdio_o,   // Management data out
  output logic             mdio_oe,  // Drive enable
  pbm_mgmt_if.engine       bus       // Register access
);

  logic [1:0]  mdc_s_r, mdio_s_r;
  logic        mdc_d_r;
  pbm_pkg::pbm_mdio_state_type st_r, st_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [1:0]  op_r, op_nxt;
  logic        rd_r, rd_nxt, wr_r, wr_nxt;
  logic        o_r, o_nxt, oe_r, oe_nxt;
  logic [4:0]  a_r, a_nxt;
  logic        rise, bit_in;

  // Pins cross from the host's clock; the edge detector reads only stage two
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_s_r  <= 2'h0;
      mdio_s_r <= 2'h3;
      mdc_d_r  <= 1'h0;
    end else begin
      mdc_s_r  <= {mdc_s_r[0], mdc};
      mdio_s_r <= {mdio_s_r[0], mdio_i};
      mdc_d_r  <= mdc_s_r[1];
    end
  end

  assign rise   = mdc_s_r[1] & ~mdc_d_r;
  assign bit_in = mdio_s_r[1];

  // Frame sequencer; one step per management clock rising edge
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    op_nxt  = op_r;
    rd_nxt  = 1'b0;
    wr_nxt  = 1'b0;
    o_nxt   = o_r;
    oe_nxt  = oe_r;
    a_nxt   = a_r;
    if (rd_r) begin
      sh_nxt = bus.rdata;  // Captured before the read clears latched bits
    end
    if (rise) begin
      case (st_r)
        // Full preamble is needed only after reset or a bad frame
        pbm_pkg::ST_PRE: begin  // RQ14
          cnt_nxt = bit_in ? cnt_r + 6'h01 : 6'h00;
          if (bit_in && cnt_r == pbm_pkg::PREAMBLE_LAST) begin
            st_nxt = pbm_pkg::ST_IDLE;
          end
        end
        pbm_pkg::ST_IDLE: begin
          if (!bit_in) begin
            st_nxt = pbm_pkg::ST_START;
          end
        end
        pbm_pkg::ST_START: begin
          cnt_nxt = 6'h00;
          st_nxt  = bit_in ? pbm_pkg::ST_OP : pbm_pkg::ST_PRE;
        end
        pbm_pkg::ST_OP: begin
          op_nxt  = {op_r[0], bit_in};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r != 6'h00) begin
            cnt_nxt = 6'h00;
            if ({op_r[0], bit_in} == pbm_pkg::OP_READ || {op_r[0], bit_in} == pbm_pkg::OP_WRITE) begin
              st_nxt = pbm_pkg::ST_ADDR;
            end else begin
              st_nxt = pbm_pkg::ST_PRE;  // RQ14
            end
          end
        end
        pbm_pkg::ST_ADDR: begin
          sh_nxt  = {sh_r[14:0], bit_in};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == pbm_pkg::ADDR_LAST) begin
            // Only the 32 direct indices exist on this bus
            a_nxt   = {sh_r[3:0], bit_in};  // RQ15
            cnt_nxt = 6'h00;
            st_nxt  = pbm_pkg::ST_TA;
            if (op_r == pbm_pkg::OP_READ && sh_r[8:4] == PHY_ADDR) begin
              rd_nxt = 1'b1;
            end
            op_nxt = (sh_r[8:4] == PHY_ADDR) ? op_r : 2'h0;  // Foreign frame: stay silent
          end
        end
        pbm_pkg::ST_TA: begin
          cnt_nxt = cnt_r + 6'h01;
          if (op_r == pbm_pkg::OP_READ) begin
            oe_nxt = 1'b1;
            o_nxt  = (cnt_r == 6'h00) ? 1'b0 : sh_r[15];
          end
          if (cnt_r != 6'h00) begin
            cnt_nxt = 6'h00;
            st_nxt  = pbm_pkg::ST_DATA;
            if (op_r == pbm_pkg::OP_READ) begin
              sh_nxt = {sh_r[14:0], 1'b0};
            end else if (op_r == pbm_pkg::OP_WRITE && {sh_r[0], bit_in} != pbm_pkg::TA_WRITE) begin
              st_nxt = pbm_pkg::ST_PRE;  // RQ14
            end
          end
          if (op_r != pbm_pkg::OP_READ && cnt_r == 6'h00) begin
            sh_nxt = {sh_r[14:0], bit_in};
          end
        end
        default: begin  // ST_DATA
          cnt_nxt = cnt_r + 6'h01;
          if (op_r == pbm_pkg::OP_READ) begin
            o_nxt  = sh_r[15];
            sh_nxt = {sh_r[14:0], 1'b0};
          end else begin
            sh_nxt = {sh_r[14:0], bit_in};
          end
          if (cnt_r == pbm_pkg::DATA_LAST) begin
            oe_nxt = 1'b0;
            o_nxt  = 1'b0;
            wr_nxt = (op_r == pbm_pkg::OP_WRITE);
            st_nxt = pbm_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r  <= pbm_pkg::ST_PRE;
      cnt_r <= 6'h00;
      sh_r  <= 16'h0000;
      op_r  <= 2'h0;
      rd_r  <= 1'h0;
      wr_r  <= 1'h0;
      o_r   <= 1'h0;
      oe_r  <= 1'h0;
      a_r   <= 5'h00;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      op_r  <= op_nxt;
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      o_r   <= o_nxt;
      oe_r  <= oe_nxt;
      a_r   <= a_nxt;
    end
  end

  assign bus.rd_stb = rd_r;
  assign bus.wr_stb = wr_r;
  assign bus.addr   = a_r;
  assign bus.wdata  = sh_r;
  assign mdio_o     = o_r;
  assign mdio_oe    = oe_r;

  // Bus is released once the last data bit has been sampled
  property p_release;
    @(posedge clk) disable iff (sys_rst) (st_r == pbm_pkg::ST_IDLE) |-> !mdio_oe;
  endproperty
  a_release: assert property (p_release) else $error("data line still driven when idle");  // RQ14

endmodule  // pbm_mdio_slave

// file: verilog/pbm_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Writing one to control bit 15 resets the standard registers and the bit clears itself when done.
// [RQ2] Control bit 15 reads one while a software reset runs and zero otherwise.
// [RQ3] Software reset leaves maker-specific extended registers untouched.
// [RQ4] Control bit 14 loops MAC-side transmit data back to the MAC-side receive outputs.
// [RQ5] No link-up indication is produced while MAC-side loopback is on.
// [RQ6] Control bit 13 is read-only and always reads one for 100 Mbps.
// [RQ7] Control bit 12 is read-only and reads zero.
// [RQ8] Control bit 11 powers the device down, leaving only register access working.
// [RQ9] Power-down is bit 11 OR the asserted low pin, and the pin sets bit 11.
// [RQ10] Control bit 10 isolates the port from the MAC side while management keeps working.
// [RQ11] Status bits 15 to 11 read zero, link latches low, remote fault and jabber latch high.
// [RQ12] The status word is index one with preamble suppression, AN complete and extended capability reading one.
// [RQ13] Latched-high bits hold one until read; latched-low bits hold zero until read, then track the condition.
// [RQ14] After reset or a bad opcode or turnaround a full 32-bit preamble is needed, later frames may skip it.
// [RQ15] Only indices 0x0 to 0x1F are reachable directly by the host.
// [RQ16] When isolated the MAC-side outputs float and MAC-side transmit inputs are ignored.
// [RQ17] Writes to read-only and reserved bits are ignored and reads give their fixed values.
module pbm_top #(
  parameter logic [4:0] PHY_ADDR = pbm_pkg::PHY_ADDR_DFLT
) (
  input  wire logic       clk,                  // 20 MHz system clock
  input  wire logic       sys_rst,              // Async reset, active high
  input  wire logic       mdc,                  // Management clock pin
  input  wire logic       mdio_i,               // Management data in
  output logic            mdio_o,               // Management data out
  output logic            mdio_oe,              // Management data drive enable
  input  wire logic       irq_powerdown_pin_n,  // Power-down pin, active low
  input  wire logic       mac_tx_en,            // MAC transmit enable
  input  wire logic [3:0] mac_txd,              // MAC transmit data
  output logic            mac_rx_dv,            // MAC receive valid
  output logic [3:0]      mac_rxd,              // MAC receive data
  output logic            mac_out_oe,           // MAC-side output enable
  output logic            line_tx_en,           // To line coder: transmit enable
  output logic [3:0]      line_txd,             // To line coder: transmit data
  input  wire logic       line_rx_dv,           // From line coder: receive valid
  input  wire logic [3:0] line_rxd,             // From line coder: receive data
  input  wire logic       line_link_ok,         // Line link condition
  input  wire logic       line_remote_fault,    // Remote fault event
  input  wire logic       line_jabber,          // Jabber event
  output logic            link_up,              // Link indication
  output logic            powerdown,            // Effective power-down
  output logic            coding_sublayer_rst   // Soft reset in progress
);

  localparam int SRST_N = pbm_pkg::SRST_CYCLES;

  pbm_mgmt_if bus ();

  logic [1:0] pin_s_r;
  logic       loop_r, loop_nxt, pd_r, pd_nxt, iso_r, iso_nxt;
  logic [5:0] srst_cnt_r, srst_cnt_nxt;
  logic       link_lat_r, link_lat_nxt, rf_r, rf_nxt, jab_r, jab_nxt;
  logic       rx_dv_r, rx_dv_nxt, tx_en_r, tx_en_nxt, oe_r, oe_nxt, lnk_r, lnk_nxt;
  logic [3:0] rxd_r, rxd_nxt, txd_r, txd_nxt;
  logic       srst_busy, srst_end, pin_pd, pd_eff, link_cond, active, rd_stat, wr_ctrl;

  // --------------------------------------------------------------------
  // Management frame engine
  // --------------------------------------------------------------------
  pbm_mdio_slave #(.PHY_ADDR(PHY_ADDR)) u_mdio (
    .clk     (clk),
    .sys_rst (sys_rst),
    .mdc     (mdc),
    .mdio_i  (mdio_i),
    .mdio_o  (mdio_o),
    .mdio_oe (mdio_oe),
    .bus     (bus)
  );

  // --------------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------------

  // Power-down pin is asynchronous; two stages before use
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s_r <= 2'h3;
    end else begin
      pin_s_r <= {pin_s_r[0], irq_powerdown_pin_n};
    end
  end

  assign pin_pd    = ~pin_s_r[1];
  assign pd_eff    = pd_r | pin_pd;  // RQ9
  assign srst_busy = (srst_cnt_r != 6'h00);
  assign srst_end  = (srst_cnt_r == 6'h01);
  assign rd_stat   = bus.rd_stb && (bus.addr == pbm_pkg::REG_STAT_IDX);
  assign wr_ctrl   = bus.wr_stb && (bus.addr == pbm_pkg::REG_CTRL_IDX);
  assign link_cond = line_link_ok & ~loop_r & ~pd_eff;  // RQ5

  // Read mux; fixed fields are constants so writes cannot reach them
  always_comb begin
    bus.rdata = 16'h0000;
    if (bus.addr == pbm_pkg::REG_CTRL_IDX) begin
      bus.rdata = pbm_pkg::CTRL_FIXED;  // RQ6 RQ7 RQ17
      bus.rdata[pbm_pkg::CTRL_RST_BIT]  = srst_busy;  // RQ2
      bus.rdata[pbm_pkg::CTRL_LOOP_BIT] = loop_r;
      bus.rdata[pbm_pkg::CTRL_PD_BIT]   = pd_r;
      bus.rdata[pbm_pkg::CTRL_ISO_BIT]  = iso_r;
    end else if (bus.addr == pbm_pkg::REG_STAT_IDX) begin
      bus.rdata = pbm_pkg::STAT_FIXED;  // RQ11 RQ12
      bus.rdata[pbm_pkg::STAT_RFAULT_BIT] = rf_r;
      bus.rdata[pbm_pkg::STAT_LINK_BIT]   = link_lat_r;
      bus.rdata[pbm_pkg::STAT_JAB_BIT]    = jab_r;
    end
  end

  // Control and status next state; events win over read clears
  always_comb begin
    loop_nxt     = loop_r;
    pd_nxt       = pd_r;
    iso_nxt      = iso_r;
    srst_cnt_nxt = srst_cnt_r;
    link_lat_nxt = rd_stat ? link_cond : (link_lat_r & link_cond);  // RQ11 RQ13
    rf_nxt       = line_remote_fault | (rf_r & ~rd_stat);  // RQ13
    jab_nxt      = line_jabber | (jab_r & ~rd_stat);  // RQ13
    if (wr_ctrl && !srst_busy) begin
      loop_nxt = bus.wdata[pbm_pkg::CTRL_LOOP_BIT];
      pd_nxt   = bus.wdata[pbm_pkg::CTRL_PD_BIT];
      iso_nxt  = bus.wdata[pbm_pkg::CTRL_ISO_BIT];
      if (bus.wdata[pbm_pkg::CTRL_RST_BIT]) begin
        srst_cnt_nxt = pbm_pkg::SRST_CNT_LOAD;  // RQ1
      end
    end else if (srst_busy) begin
      srst_cnt_nxt = srst_cnt_r - 6'h01;  // RQ1
      if (srst_end) begin
        // Only the standard set returns to defaults; extended space has no reset path here
        loop_nxt     = 1'b0;  // RQ3
        pd_nxt       = 1'b0;
        iso_nxt      = 1'b0;
        link_lat_nxt = 1'b0;
        rf_nxt       = line_remote_fault;
        jab_nxt      = line_jabber;
      end
    end
    if (pin_pd) begin
      pd_nxt = 1'b1;  // RQ9
    end
  end

  // Control and status registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_r     <= 1'h0;
      pd_r       <= 1'h0;
      iso_r      <= 1'h0;
      srst_cnt_r <= 6'h00;
      link_lat_r <= 1'h0;
      rf_r       <= 1'h0;
      jab_r      <= 1'h0;
    end else begin
      loop_r     <= loop_nxt;
      pd_r       <= pd_nxt;
      iso_r      <= iso_nxt;
      srst_cnt_r <= srst_cnt_nxt;
      link_lat_r <= link_lat_nxt;
      rf_r       <= rf_nxt;
      jab_r      <= jab_nxt;
    end
  end

  // --------------------------------------------------------------------
  // MAC-side data path
  // --------------------------------------------------------------------

  // Data path is quiet in power-down, isolation and soft reset
  assign active = ~pd_eff & ~iso_r & ~srst_busy;  // RQ8 RQ10

  always_comb begin
    tx_en_nxt = active & ~loop_r & mac_tx_en;  // RQ16
    txd_nxt   = tx_en_nxt ? mac_txd : 4'h0;
    rx_dv_nxt = active & (loop_r ? mac_tx_en : line_rx_dv);  // RQ4
    rxd_nxt   = rx_dv_nxt ? (loop_r ? mac_txd : line_rxd) : 4'h0;
    oe_nxt    = ~iso_r;  // RQ16
    lnk_nxt   = link_cond & ~srst_busy;  // RQ5 RQ8
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_en_r <= 1'h0;
      txd_r   <= 4'h0;
      rx_dv_r <= 1'h0;
      rxd_r   <= 4'h0;
      oe_r    <= 1'h0;
      lnk_r   <= 1'h0;
    end else begin
      tx_en_r <= tx_en_nxt;
      txd_r   <= txd_nxt;
      rx_dv_r <= rx_dv_nxt;
      rxd_r   <= rxd_nxt;
      oe_r    <= oe_nxt;
      lnk_r   <= lnk_nxt;
    end
  end

  assign line_tx_en          = tx_en_r;
  assign line_txd            = txd_r;
  assign mac_rx_dv           = rx_dv_r;
  assign mac_rxd             = rxd_r;
  assign mac_out_oe          = oe_r;
  assign link_up             = lnk_r;
  assign powerdown           = pd_eff;
  assign coding_sublayer_rst = srst_busy;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_srst_run;
    srst_busy [*8];
  endsequence
  property p_srst_clear;
    $rose(srst_busy) |-> s_srst_run ##[1:SRST_N] !srst_busy;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset did not self clear");  // RQ1

  property p_srst_read;
    (bus.addr == pbm_pkg::REG_CTRL_IDX) |-> (bus.rdata[pbm_pkg::CTRL_RST_BIT] == srst_busy);
  endproperty
  a_srst_read: assert property (p_srst_read) else $error("reset bit readback wrong");  // RQ2

  property p_loop_route;
    (loop_r && active && mac_tx_en) |=> (mac_rx_dv && mac_rxd == $past(mac_txd) && !line_tx_en);
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback data not returned");  // RQ4

  property p_loop_nolink;
    loop_r |=> !link_up;
  endproperty
  a_loop_nolink: assert property (p_loop_nolink) else $error("link shown during loopback");  // RQ5

  property p_ctrl_fixed;
    (bus.addr == pbm_pkg::REG_CTRL_IDX) |-> (bus.rdata[pbm_pkg::CTRL_SPEED_BIT] && !bus.rdata[pbm_pkg::CTRL_ANEN_BIT]
                                              && bus.rdata[9:0] == pbm_pkg::CTRL_RSVD_VAL);
  endproperty
  a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("fixed control fields wrong");  // RQ6

  property p_pd_quiet;
    pd_eff |=> (!line_tx_en && !mac_rx_dv && !link_up);
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("activity during power-down");  // RQ8

  property p_pin_sets_pd;
    pin_pd |=> pd_r;
  endproperty
  a_pin_sets_pd: assert property (p_pin_sets_pd) else $error("pin did not set power-down bit");  // RQ9

  property p_isolate;
    iso_r |=> (!mac_out_oe && !line_tx_en && !mac_rx_dv);
  endproperty
  a_isolate: assert property (p_isolate) else $error("isolated port still active");  // RQ10

  property p_stat_fixed;
    (bus.addr == pbm_pkg::REG_STAT_IDX) |-> (bus.rdata[15:7] == 9'h000 && bus.rdata[6] && bus.rdata[5]
                                              && !bus.rdata[3] && bus.rdata[0]);
  endproperty
  a_stat_fixed: assert property (p_stat_fixed) else $error("fixed status fields wrong");  // RQ12

  property p_lh_hold;
    (jab_r && !rd_stat && !srst_end) |=> jab_r;
  endproperty
  a_lh_hold: assert property (p_lh_hold) else $error("latched jabber lost before read");  // RQ13

  property p_ll_drop;
    (!link_cond && !rd_stat) |=> !link_lat_r ##1 (!link_lat_r || $past(rd_stat));
  endproperty
  a_ll_drop: assert property (p_ll_drop) else $error("latched link did not hold low");  // RQ11

endmodule  // pbm_top

// file: dv/pbm_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Station management host: clause 22 frames on the management line
// ----------------------------------------------------------------------
module pbm_host_model (
  input  wire logic clk,      // System clock, paces the frame
  input  wire logic mdio,     // Resolved management line
  output logic      mdc,      // Management clock, still between frames
  output logic      host_oe,  // Host drive enable
  output logic      host_do   // Host drive value
);
  logic        smp;      // Line value at the last rising mdc
  logic [15:0] rd_word;  // Word from the last read frame

  initial begin
    mdc = 1'b0;
    host_oe = 1'b0;
    host_do = 1'b1;
  end

  // Ten system clocks a half period: 1 MHz, well inside the synchroniser limit
  task half();
    repeat (10) @(posedge clk);
    #5;
  endtask

  // One bit: data set while mdc is low, line sampled just before the rise
  task cyc(input logic b, input logic drv);
    host_oe = drv;
    host_do = b;
    half();
    smp = mdio;
    mdc = 1'b1;
    half();
    mdc = 1'b0;
  endtask

  // Whole frame; preamble only where the device needs it again
  task frame(input logic wr, input logic [4:0] ra, input logic [15:0] wd, input logic pre, input logic [4:0] pa);
    logic [13:0] hdr;
    logic [17:0] tl;
    hdr = {2'b01, (wr ? 2'b01 : 2'b10), pa, ra};
    tl = {2'b10, wd};
    if (pre) for (int i = 0; i < 32; i++) cyc(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--) cyc(hdr[i], 1'b1);
    if (wr) for (int i = 17; i >= 0; i--) cyc(tl[i], 1'b1);
    else begin
      cyc(1'b1, 1'b0);
      cyc(1'b1, 1'b0);
      for (int i = 15; i >= 0; i--) begin
        cyc(1'b1, 1'b0);
        rd_word[i] = smp;
      end
    end
    host_oe = 1'b0;  // Released: the pull-up takes the line high
  endtask
endmodule  // pbm_host_model

// file: dv/pbm_top_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Self-checking bench for the basic mode registers
// ----------------------------------------------------------------------
module pbm_top_test;
  logic clk, sys_rst, mdc, mdio, host_oe, host_do, mdio_o, mdio_oe, pin_n, tx_en, rx_dv, out_oe;
  logic line_tx_en, line_rx_dv, link_ok, rfault, jab, link_up, powerdown, cs_rst;
  logic [3:0]  txd, rxd, line_txd, line_rxd;
  logic [15:0] d;
  int          bad_count, tests_run, n;

  // Line has a pull-up; the device wins while it drives
  assign mdio = mdio_oe ? mdio_o : (host_oe ? host_do : 1'b1);

  pbm_top i_pbm_top (.clk(clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_i(mdio), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .irq_powerdown_pin_n(pin_n), .mac_tx_en(tx_en), .mac_txd(txd),
    .mac_rx_dv(rx_dv), .mac_rxd(rxd), .mac_out_oe(out_oe), .line_tx_en(line_tx_en),
    .line_txd(line_txd), .line_rx_dv(line_rx_dv), .line_rxd(line_rxd), .line_link_ok(link_ok),
    .line_remote_fault(rfault), .line_jabber(jab), .link_up(link_up), .powerdown(powerdown),
    .coding_sublayer_rst(cs_rst));
  pbm_host_model i_pbm_host_model (.clk(clk), .mdio(mdio), .mdc(mdc), .host_oe(host_oe), .host_do(host_do));

  always #25 clk = ~clk;

  task finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask

  task wr(input logic [4:0] ra, input logic [15:0] v);
    i_pbm_host_model.frame(1'b1, ra, v, 1'b0, 5'h00);
  endtask

  task rd(input logic [4:0] ra);
    i_pbm_host_model.frame(1'b0, ra, 16'h0000, 1'b0, 5'h00);
    d = i_pbm_host_model.rd_word;
  endtask

  // Fixed fields, ignored writes, foreign address and unmapped index
  task t_defaults();
    i_pbm_host_model.frame(1'b0, pbm_pkg::REG_CTRL_IDX, 16'h0000, 1'b1, 5'h00);
    chk("ctrl reset", 16'h2100, i_pbm_host_model.rd_word);
    rd(pbm_pkg::REG_STAT_IDX);
    chk("stat reset", 16'h0061, d);
    wr(pbm_pkg::REG_CTRL_IDX, 16'h10FF);
    rd(pbm_pkg::REG_CTRL_IDX);
    chk("ctrl ro", 16'h2100, d);
    wr(pbm_pkg::REG_STAT_IDX, 16'hFFFF);
    rd(pbm_pkg::REG_STAT_IDX);
    chk("stat ro", 16'h0061, d);
    i_pbm_host_model.frame(1'b1, pbm_pkg::REG_CTRL_IDX, 16'h4100, 1'b0, 5'h03);
    rd(pbm_pkg::REG_CTRL_IDX);
    chk("ctrl other phy", 16'h2100, d);
    rd(5'h05);
    chk("unmapped", 16'h0000, d);
    $display("defaults test done");
  endtask

  // Latched link low and latched events high
  task t_latch();
    link_ok = 1'b1;
    tick(2);
    rd(pbm_pkg::REG_STAT_IDX);
    chk("link held low", 16'h0061, d);
    rd(pbm_pkg::REG_STAT_IDX);
    chk("link now", 16'h0065, d);
    chk("link_up", 16'h0001, {15'h0, link_up});
    {rfault, jab, link_ok} = 3'b110;
    tick(1);
    {rfault, jab, link_ok} = 3'b001;
    rd(pbm_pkg::REG_STAT_IDX);
    chk("events", 16'h0073, d);
    rd(pbm_pkg::REG_STAT_IDX);
    chk("events cleared", 16'h0065, d);
    $display("latch test done");
  endtask

  // MAC-side loopback and no link while it is on
  task t_loop();
    wr(pbm_pkg::REG_CTRL_IDX, 16'h6100);
    tick(2);
    chk("loop link_up", 16'h0000, {15'h0, link_up});
    tx_en = 1'b1;
    txd = 4'hA;
    tick(2);
    chk("loop data", 16'h0034, {10'h0, rx_dv, rxd, line_tx_en});
    tx_en = 1'b0;
    wr(pbm_pkg::REG_CTRL_IDX, 16'h2100);
    tick(2);
    chk("loop off link", 16'h0001, {15'h0, link_up});
    $display("loopback test done");
  endtask

  // Pin sets the power-down bit; software clears it
  task t_pd();
    pin_n = 1'b0;
    tick(4);
    chk("pin powerdown", 16'h0001, {15'h0, powerdown});
    pin_n = 1'b1;
    rd(pbm_pkg::REG_CTRL_IDX);
    chk("pd bit", 16'h2900, d);
    chk("pd link_up", 16'h0000, {15'h0, link_up});
    wr(pbm_pkg::REG_CTRL_IDX, 16'h2100);
    tick(4);
    chk("pd cleared", 16'h0000, {15'h0, powerdown});
    $display("power-down test done");
  endtask

  // Isolation floats the MAC side, management still answers
  task t_iso();
    wr(pbm_pkg::REG_CTRL_IDX, 16'h2500);
    tx_en = 1'b1;
    txd = 4'h5;
    tick(2);
    chk("isolated", 16'h0000, {14'h0, out_oe, line_tx_en});
    rd(pbm_pkg::REG_CTRL_IDX);
    chk("iso ctrl", 16'h2500, d);
    tx_en = 1'b0;
    wr(pbm_pkg::REG_CTRL_IDX, 16'h2100);
    tick(2);
    chk("iso off", 16'h0001, {15'h0, out_oe});
    tx_en = 1'b1;
    line_rx_dv = 1'b1;
    line_rxd = 4'h3;
    tick(2);
    chk("normal path", 16'h0275, {6'h0, rx_dv, rxd, line_tx_en, line_txd});
    {tx_en, line_rx_dv} = 2'b00;
    $display("isolate test done");
  endtask

  // Soft reset runs, clears itself and restores defaults
  task t_srst();
    wr(pbm_pkg::REG_CTRL_IDX, 16'hE100);
    chk("srst busy", 16'h0001, {15'h0, cs_rst});
    n = 0;
    while (cs_rst === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk("srst done", 16'h0000, {15'h0, cs_rst});
    rd(pbm_pkg::REG_CTRL_IDX);
    chk("srst ctrl", 16'h2100, d);
    $display("soft reset test done");
  endtask

  // A bad start bit demands a fresh preamble before frames count again
  task t_resync();
    i_pbm_host_model.cyc(1'b0, 1'b1);
    i_pbm_host_model.cyc(1'b0, 1'b1);
    wr(pbm_pkg::REG_CTRL_IDX, 16'h6100);
    i_pbm_host_model.frame(1'b0, pbm_pkg::REG_CTRL_IDX, 16'h0000, 1'b1, 5'h00);
    chk("resync", 16'h2100, i_pbm_host_model.rd_word);
    $display("resync test done");
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    pin_n = 1'b1;
    tx_en = 1'b0;
    txd = 4'h0;
    line_rx_dv = 1'b0;
    line_rxd = 4'h0;
    {link_ok, rfault, jab} = 3'b000;
    tick(16);
    sys_rst = 1'b0;
    tick(2);
    t_defaults();
    t_latch();
    t_loop();
    t_pd();
    t_iso();
    t_srst();
    t_resync();
    finish_test();
  end

  // About 25 frames of some 700 cycles each; generous margin
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule  // pbm_top_test
